//--- core/bam_consts.vh
// constants for the decimal adjust and multiply decoder
// Function
// [RQ1] 00101111 decodes decimal adjust, 4 clocks
// [RQ2] 00111111 decodes ascii adjust, 7 clocks
// [RQ3] 1111011w reg 100 unsigned product, timed
// [RQ4] 1111011w reg 101 signed product, timed
// [RQ5] 011010s1 modrm immediate signed product, timed
// [RQ6] second immediate byte only when s=0
// [RQ7] w selects byte/word; s sign-extends byte
`ifndef BAM_CONSTS_VH
`define BAM_CONSTS_VH

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define BAM_OPC_DEC_ADJ     8'h2F
`define BAM_OPC_ASC_ADJ     8'h3F
`define BAM_OPC_GRP_HI      7'h7B
`define BAM_OPC_IMM_PAT     7'h35
`define BAM_REG_UNSIGNED    3'h4
`define BAM_REG_SIGNED      3'h5
`define BAM_MOD_REG         2'h3
`define BAM_MOD_NODISP      2'h0
`define BAM_MOD_DISP8       2'h1
`define BAM_RM_DIRECT       3'h6

// ----------------------------------------------------------------
// operation codes reported on the op output, plus the internal group code BAM_OP_GRP that is never reported
// ----------------------------------------------------------------
`define BAM_OP_NONE         3'h0
`define BAM_OP_DEC_ADJ      3'h1
`define BAM_OP_ASC_ADJ      3'h2
`define BAM_OP_UNS_PROD     3'h3
`define BAM_OP_SGN_PROD     3'h4
`define BAM_OP_SGN_IMM      3'h5
`define BAM_OP_GRP          3'h6

// ----------------------------------------------------------------
// execution clock counts, min and max
// ----------------------------------------------------------------
`define BAM_CLK_DEC_ADJ     6'h04
`define BAM_CLK_ASC_ADJ     6'h07
`define BAM_CLK_UNS_RB_MIN  6'd26
`define BAM_CLK_UNS_RB_MAX  6'd28
`define BAM_CLK_UNS_RW_MIN  6'd35
`define BAM_CLK_UNS_RW_MAX  6'd37
`define BAM_CLK_UNS_MB_MIN  6'd32
`define BAM_CLK_UNS_MB_MAX  6'd34
`define BAM_CLK_UNS_MW_MIN  6'd41
`define BAM_CLK_UNS_MW_MAX  6'd43
`define BAM_CLK_SGN_RB_MIN  6'd25
`define BAM_CLK_SGN_RB_MAX  6'd28
`define BAM_CLK_SGN_RW_MIN  6'd34
`define BAM_CLK_SGN_RW_MAX  6'd37
`define BAM_CLK_SGN_MB_MIN  6'd31
`define BAM_CLK_SGN_MB_MAX  6'd34
`define BAM_CLK_SGN_MW_MIN  6'd40
`define BAM_CLK_SGN_MW_MAX  6'd43
`define BAM_CLK_IMM_R_MIN   6'd22
`define BAM_CLK_IMM_R_MAX   6'd25
`define BAM_CLK_IMM_M_MIN   6'd29
`define BAM_CLK_IMM_M_MAX   6'd32

`endif

//--- core/bam_clocks.v
// execution clock count lookup per operation and operand form
`timescale 1ns/1ns
`default_nettype none
`include "bam_consts.vh"

module bam_clocks (
  input  wire [2:0] i_op,
  input  wire       i_wide,
  input  wire       i_mem,
  output reg  [5:0] o_min,
  output reg  [5:0] o_max
);

  always @* begin
    o_min = `BAM_CLK_DEC_ADJ;
    o_max = `BAM_CLK_DEC_ADJ;
    case (i_op)
      `BAM_OP_DEC_ADJ: begin
        o_min = `BAM_CLK_DEC_ADJ; // RQ1
        o_max = `BAM_CLK_DEC_ADJ;
      end
      `BAM_OP_ASC_ADJ: begin
        o_min = `BAM_CLK_ASC_ADJ; // RQ2
        o_max = `BAM_CLK_ASC_ADJ;
      end
      `BAM_OP_UNS_PROD: begin
        case ({i_mem, i_wide}) // RQ3
          2'b00: begin o_min = `BAM_CLK_UNS_RB_MIN; o_max = `BAM_CLK_UNS_RB_MAX; end
          2'b01: begin o_min = `BAM_CLK_UNS_RW_MIN; o_max = `BAM_CLK_UNS_RW_MAX; end
          2'b10: begin o_min = `BAM_CLK_UNS_MB_MIN; o_max = `BAM_CLK_UNS_MB_MAX; end
          default: begin o_min = `BAM_CLK_UNS_MW_MIN; o_max = `BAM_CLK_UNS_MW_MAX; end
        endcase
      end
      `BAM_OP_SGN_PROD: begin
        case ({i_mem, i_wide}) // RQ4
          2'b00: begin o_min = `BAM_CLK_SGN_RB_MIN; o_max = `BAM_CLK_SGN_RB_MAX; end
          2'b01: begin o_min = `BAM_CLK_SGN_RW_MIN; o_max = `BAM_CLK_SGN_RW_MAX; end
          2'b10: begin o_min = `BAM_CLK_SGN_MB_MIN; o_max = `BAM_CLK_SGN_MB_MAX; end
          default: begin o_min = `BAM_CLK_SGN_MW_MIN; o_max = `BAM_CLK_SGN_MW_MAX; end
        endcase
      end
      `BAM_OP_SGN_IMM: begin
        if (i_mem) begin // RQ5
          o_min = `BAM_CLK_IMM_M_MIN;
          o_max = `BAM_CLK_IMM_M_MAX;
        end else begin
          o_min = `BAM_CLK_IMM_R_MIN;
          o_max = `BAM_CLK_IMM_R_MAX;
        end
      end
      default: begin
        o_min = `BAM_CLK_DEC_ADJ;
        o_max = `BAM_CLK_DEC_ADJ;
      end
    endcase
  end

endmodule // bam_clocks
`default_nettype wire

//--- core/bam_decode.v
// byte-stream decoder and execution timer for adjust and multiply instructions
`timescale 1ns/1ns
`default_nettype none
`include "bam_consts.vh"

module bam_decode (
  input  wire        I_CLK_SYS,
  input  wire        I_RESET_N,
  input  wire        i_BYTE_VALID,
  input  wire [7:0]  i_BYTE,
  output reg         o_BYTE_READY,
  output reg         o_DONE,
  output reg         o_ILLEGAL,
  output reg  [2:0]  o_OP,
  output reg         o_WIDE,
  output reg         o_MEM,
  output reg  [7:0]  o_MODRM,
  output reg  [15:0] o_IMM,
  output reg  [5:0]  o_CLK_MIN,
  output reg  [5:0]  o_CLK_MAX
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] S_OPC    = 3'h0;
  localparam [2:0] S_MODRM  = 3'h1;
  localparam [2:0] S_DISP   = 3'h2;
  localparam [2:0] S_IMM_LO = 3'h3;
  localparam [2:0] S_IMM_HI = 3'h4;
  localparam [2:0] S_EXEC   = 3'h5;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [1:0] disp_len;
    input [7:0] modrm;
    begin
      if (modrm[7:6] == `BAM_MOD_DISP8)
        disp_len = 2'd1;
      else if (modrm[7:6] == `BAM_MOD_REG)
        disp_len = 2'd0;
      else if (modrm[7:6] == `BAM_MOD_NODISP)
        disp_len = (modrm[2:0] == `BAM_RM_DIRECT) ? 2'd2 : 2'd0;
      else
        disp_len = 2'd2;
    end
  endfunction

  // product kind from the modrm reg field, none for foreign fields
  function [2:0] prod_op;
    input [7:0] modrm;
    begin
      if (modrm[5:3] == `BAM_REG_UNSIGNED)
        prod_op = `BAM_OP_UNS_PROD;
      else if (modrm[5:3] == `BAM_REG_SIGNED)
        prod_op = `BAM_OP_SGN_PROD;
      else
        prod_op = `BAM_OP_NONE;
    end
  endfunction

  reg  [2:0]  state;
  reg  [2:0]  op;
  reg         wide;
  reg         mem;
  reg         sext;
  reg  [7:0]  modrm;
  reg  [1:0]  disp_left;
  reg  [15:0] imm;
  reg  [5:0]  count;
  wire [5:0]  clk_min;
  wire [5:0]  clk_max;
  wire        take;

  assign take = i_BYTE_VALID & o_BYTE_READY;

  bam_clocks u_clocks (
    .i_op   (op),
    .i_wide (wide),
    .i_mem  (mem),
    .o_min  (clk_min),
    .o_max  (clk_max)
  );

  // ----------------------------------------------------------------
  // decode and execution sequencer
  // ----------------------------------------------------------------
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state        <= S_OPC;
      op           <= `BAM_OP_NONE;
      wide         <= 1'b0;
      mem          <= 1'b0;
      sext         <= 1'b0;
      modrm        <= 8'h00;
      disp_left    <= 2'd0;
      imm          <= 16'h0000;
      count        <= 6'h00;
      o_BYTE_READY <= 1'b0;
      o_DONE       <= 1'b0;
      o_ILLEGAL    <= 1'b0;
      o_OP         <= `BAM_OP_NONE;
      o_WIDE       <= 1'b0;
      o_MEM        <= 1'b0;
      o_MODRM      <= 8'h00;
      o_IMM        <= 16'h0000;
      o_CLK_MIN    <= 6'h00;
      o_CLK_MAX    <= 6'h00;
    end else begin
      o_DONE       <= 1'b0;
      o_ILLEGAL    <= 1'b0;
      o_BYTE_READY <= 1'b1;
      case (state)
        S_OPC: begin
          if (take) begin
            mem   <= 1'b0;
            sext  <= 1'b0;
            imm   <= 16'h0000;
            modrm <= 8'h00;
            count <= 6'h00;
            if (i_BYTE == `BAM_OPC_DEC_ADJ) begin
              op           <= `BAM_OP_DEC_ADJ; // RQ1
              wide         <= 1'b0;
              state        <= S_EXEC;
              o_BYTE_READY <= 1'b0;
            end else if (i_BYTE == `BAM_OPC_ASC_ADJ) begin
              op           <= `BAM_OP_ASC_ADJ; // RQ2
              wide         <= 1'b0;
              state        <= S_EXEC;
              o_BYTE_READY <= 1'b0;
            end else if (i_BYTE[7:1] == `BAM_OPC_GRP_HI) begin
              op    <= `BAM_OP_GRP;
              wide  <= i_BYTE[0]; // RQ7
              state <= S_MODRM;
            end else if ({i_BYTE[7:2], i_BYTE[0]} == `BAM_OPC_IMM_PAT) begin
              op    <= `BAM_OP_SGN_IMM; // RQ5
              wide  <= 1'b1;
              sext  <= i_BYTE[1]; // RQ6
              state <= S_MODRM;
            end else begin
              o_ILLEGAL <= 1'b1;
            end
          end
        end
        S_MODRM: begin
          if (take) begin
            modrm     <= i_BYTE;
            mem       <= (i_BYTE[7:6] != `BAM_MOD_REG);
            disp_left <= disp_len(i_BYTE);
            if (op == `BAM_OP_GRP && prod_op(i_BYTE) == `BAM_OP_NONE) begin
              o_ILLEGAL <= 1'b1;
              op        <= `BAM_OP_NONE;
              state     <= S_OPC;
            end else begin
              if (op == `BAM_OP_GRP)
                op <= prod_op(i_BYTE); // RQ3 RQ4
              if (disp_len(i_BYTE) != 2'd0) begin
                state <= S_DISP;
              end else if (op == `BAM_OP_SGN_IMM) begin
                state <= S_IMM_LO;
              end else begin
                state        <= S_EXEC;
                o_BYTE_READY <= 1'b0;
              end
            end
          end
        end
        S_DISP: begin
          if (take) begin
            disp_left <= disp_left - 2'd1;
            if (disp_left == 2'd1) begin
              if (op == `BAM_OP_SGN_IMM) begin
                state <= S_IMM_LO;
              end else begin
                state        <= S_EXEC;
                o_BYTE_READY <= 1'b0;
              end
            end
          end
        end
        S_IMM_LO: begin
          if (take) begin
            if (sext) begin
              imm          <= {{8{i_BYTE[7]}}, i_BYTE}; // RQ7
              state        <= S_EXEC; // RQ6
              o_BYTE_READY <= 1'b0;
            end else begin
              imm   <= {8'h00, i_BYTE};
              state <= S_IMM_HI; // RQ6
            end
          end
        end
        S_IMM_HI: begin
          if (take) begin
            imm[15:8]    <= i_BYTE; // RQ6
            state        <= S_EXEC;
            o_BYTE_READY <= 1'b0;
          end
        end
        S_EXEC: begin
          // hold the byte stream for the worst-case execution time
          count        <= count + 6'h01;
          o_BYTE_READY <= 1'b0;
          if (count == clk_max - 6'h01) begin // RQ1 RQ2 RQ3 RQ4 RQ5
            state        <= S_OPC;
            o_BYTE_READY <= 1'b1;
            o_DONE       <= 1'b1;
            o_OP         <= op;
            o_WIDE       <= wide; // RQ7
            o_MEM        <= mem;
            o_MODRM      <= modrm;
            o_IMM        <= imm;
            o_CLK_MIN    <= clk_min;
            o_CLK_MAX    <= clk_max;
          end
        end
        default: begin
          state <= S_OPC;
        end
      endcase
    end
  end

endmodule // bam_decode
`default_nettype wire

//--- dv/bam_decode_assertions.sv
// concurrent checks on the ports of the adjust and multiply decoder
`timescale 1ns/1ns
`default_nettype none
`include "bam_consts.vh"

module bam_decode_assertions (
  input wire        I_CLK_SYS,
  input wire        I_RESET_N,
  input wire        i_BYTE_VALID,
  input wire [7:0]  i_BYTE,
  input wire        o_BYTE_READY,
  input wire        o_DONE,
  input wire        o_ILLEGAL,
  input wire [2:0]  o_OP,
  input wire        o_WIDE,
  input wire        o_MEM,
  input wire [7:0]  o_MODRM,
  input wire [15:0] o_IMM,
  input wire [5:0]  o_CLK_MIN,
  input wire [5:0]  o_CLK_MAX
);
  // ----------------------------------------------------------------
  // helper: cycles spent with ready low
  // ----------------------------------------------------------------
  reg  [6:0] low_cnt;
  wire [5:0] mx = o_MEM ? (o_WIDE ? 6'd43 : 6'd34) : (o_WIDE ? 6'd37 : 6'd28);
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) low_cnt <= 7'h00;
    else low_cnt <= o_BYTE_READY ? 7'h00 : low_cnt + 7'h01;
  end
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_done_one; o_DONE |=> !o_DONE; endproperty
  property p_ill_one; o_ILLEGAL |=> !o_ILLEGAL; endproperty
  property p_timing; o_DONE |-> low_cnt == {1'b0, o_CLK_MAX} && o_BYTE_READY; endproperty
  property p_das; o_DONE && o_OP == `BAM_OP_DEC_ADJ |-> o_CLK_MAX == 6'd4 && o_CLK_MIN == 6'd4 && !o_WIDE; endproperty
  property p_aas; o_DONE && o_OP == `BAM_OP_ASC_ADJ |-> o_CLK_MAX == 6'd7 && o_CLK_MIN == 6'd7 && !o_WIDE; endproperty
  property p_uns;
    o_DONE && o_OP == `BAM_OP_UNS_PROD |-> o_CLK_MAX == mx && o_CLK_MIN == mx - 6'd2 && o_MEM == (o_MODRM[7:6] != 2'h3);
  endproperty
  property p_sgn;
    o_DONE && o_OP == `BAM_OP_SGN_PROD |-> o_CLK_MAX == mx && o_CLK_MIN == mx - 6'd3 && o_MEM == (o_MODRM[7:6] != 2'h3);
  endproperty
  property p_imm;
    o_DONE && o_OP == `BAM_OP_SGN_IMM |-> o_WIDE && o_CLK_MAX == (o_MEM ? 6'd32 : 6'd25) && o_CLK_MIN == o_CLK_MAX - 6'd3;
  endproperty
  property p_hold; !o_DONE |-> $stable({o_OP, o_WIDE, o_IMM, o_CLK_MAX}); endproperty
  a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
  a_ill_one: assert property (p_ill_one) else $error("illegal longer than one cycle");
  a_timing: assert property (p_timing) else $error("done not at max count");
  a_das: assert property (p_das) else $error("decimal adjust form wrong");
  a_aas: assert property (p_aas) else $error("ascii adjust form wrong");
  a_uns: assert property (p_uns) else $error("unsigned product count wrong");
  a_sgn: assert property (p_sgn) else $error("signed product count wrong");
  a_imm: assert property (p_imm) else $error("immediate product count wrong");
  a_hold: assert property (p_hold) else $error("results moved without done");
  c_imm: cover property (o_DONE && o_OP == `BAM_OP_SGN_IMM);
  c_ill: cover property (o_ILLEGAL);
  c_memw: cover property (o_DONE && o_MEM && o_WIDE);
endmodule // bam_decode_assertions

bind bam_decode bam_decode_assertions u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N),
  .i_BYTE_VALID(i_BYTE_VALID), .i_BYTE(i_BYTE), .o_BYTE_READY(o_BYTE_READY), .o_DONE(o_DONE),
  .o_ILLEGAL(o_ILLEGAL), .o_OP(o_OP), .o_WIDE(o_WIDE), .o_MEM(o_MEM), .o_MODRM(o_MODRM),
  .o_IMM(o_IMM), .o_CLK_MIN(o_CLK_MIN), .o_CLK_MAX(o_CLK_MAX));
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the adjust and multiply decoder
`timescale 1ns/1ns
`default_nettype none
`include "bam_consts.vh"

module testbench;
  logic        I_CLK_SYS = 1'b0;
  logic        I_RESET_N = 1'b0;
  logic        i_BYTE_VALID = 1'b0;
  logic [7:0]  i_BYTE = 8'h00;
  logic [31:0] seed = 32'h0000_5abe;
  logic [7:0]  r;
  wire         o_BYTE_READY, o_DONE, o_ILLEGAL, o_WIDE, o_MEM;
  wire  [2:0]  o_OP;
  wire  [7:0]  o_MODRM;
  wire  [15:0] o_IMM;
  wire  [5:0]  o_CLK_MIN, o_CLK_MAX;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  bam_decode dut (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .i_BYTE_VALID(i_BYTE_VALID), .i_BYTE(i_BYTE),
    .o_BYTE_READY(o_BYTE_READY), .o_DONE(o_DONE), .o_ILLEGAL(o_ILLEGAL), .o_OP(o_OP), .o_WIDE(o_WIDE),
    .o_MEM(o_MEM), .o_MODRM(o_MODRM), .o_IMM(o_IMM), .o_CLK_MIN(o_CLK_MIN), .o_CLK_MAX(o_CLK_MAX));

  always #4 I_CLK_SYS = ~I_CLK_SYS;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge I_CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // offer one byte and return just after the edge that took it
  task put(input logic [7:0] b);
    int n;
    n = 0;
    i_BYTE = b;
    i_BYTE_VALID = 1'b1;
    while (o_BYTE_READY !== 1'b1 && n < 200) begin
      @(posedge I_CLK_SYS); #1; n++;
    end
    @(posedge I_CLK_SYS); #1;
  endtask

  // send one instruction, model its results and compare at done
  task run(input logic [7:0] opc, input logic [7:0] mrm, input logic [15:0] imm);
    logic [2:0] op; logic w, m; logic [5:0] mx, mn; logic [15:0] ei; logic [7:0] em; int n;
    w = 1'b0; m = 1'b0; ei = 16'h0000; em = 8'h00; n = 0;
    put(opc);
    if (opc == 8'h2F) begin op = `BAM_OP_DEC_ADJ; mx = 6'd4; mn = 6'd4; end
    else if (opc == 8'h3F) begin op = `BAM_OP_ASC_ADJ; mx = 6'd7; mn = 6'd7; end
    else begin
      put(mrm);
      em = mrm;
      m = mrm[7:6] != 2'h3;
      if (mrm[7:6] == 2'h1) put(rnd());
      if (mrm[7:6] == 2'h2 || (mrm[7:6] == 2'h0 && mrm[2:0] == 3'h6)) begin put(rnd()); put(rnd()); end
      if (opc[7:1] == 7'h7B) begin
        w = opc[0];
        op = mrm[5:3] == 3'h4 ? `BAM_OP_UNS_PROD : `BAM_OP_SGN_PROD;
        mx = m ? (w ? 6'd43 : 6'd34) : (w ? 6'd37 : 6'd28);
        mn = mx - (op == `BAM_OP_UNS_PROD ? 6'd2 : 6'd3);
      end else begin
        w = 1'b1; op = `BAM_OP_SGN_IMM; mx = m ? 6'd32 : 6'd25; mn = mx - 6'd3;
        put(imm[7:0]);
        ei = {{8{imm[7]}}, imm[7:0]};
        if (!opc[1]) begin put(imm[15:8]); ei = imm; end
      end
    end
    i_BYTE_VALID = 1'b0;
    chk(48'(o_BYTE_READY), 48'h0);
    while (o_DONE !== 1'b1 && n < 100) begin
      @(posedge I_CLK_SYS); #1; n++;
    end
    chk(48'(n), 48'(mx));
    chk(48'(o_BYTE_READY), 48'h1);
    chk({o_OP, o_WIDE, o_MEM, o_MODRM, o_IMM, o_CLK_MIN, o_CLK_MAX}, {op, w, m, em, ei, mn, mx});
  endtask

  task bad(input logic [7:0] opc, input logic [7:0] mrm);
    put(opc);
    if (opc[7:1] == 7'h7B) put(mrm);
    i_BYTE_VALID = 1'b0;
    chk(48'(o_ILLEGAL), 48'h1);
    @(posedge I_CLK_SYS); #1;
    chk(48'({o_ILLEGAL, o_BYTE_READY}), 48'h1);
  endtask

  initial begin
    repeat (8) @(posedge I_CLK_SYS);
    #1 I_RESET_N = 1'b1;
    repeat (2) @(posedge I_CLK_SYS);
    #1;
    run(8'h2F, 8'h00, 16'h0000);
    run(8'h3F, 8'h00, 16'h0000);
    run(8'h2F, 8'h00, 16'h0000);
    $display("test adjust done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      run({7'h7B, i[0]}, {i[3:2], (i[1] ? 3'h5 : 3'h4), r[2:0]}, 16'h0000);
    end
    run(8'hF7, 8'h26, 16'h0000);
    $display("test product done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      run(i[0] ? 8'h6B : 8'h69, {i[2:1], r[5:0]}, {rnd(), i[1], r[6:0]});
    end
    run(8'h69, 8'h2E, 16'h8001);
    $display("test immediate done");
    bad(8'hF7, 8'hC0);
    bad(8'h90, 8'h00);
    run(8'h3F, 8'h00, 16'h0000);
    $display("test illegal done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
